// ---- verilog/ubss_pkg.sv ----
// Shared constants and types for both ends of the utility bus link.
// Assumes one clock, the line rate clock, common to both ends.
package ubss_pkg;

  localparam int CLK_MHZ = 50;
  // Host strobe phase time and its cycle count (least time, rounded up)
  localparam int PHASE_NS = 120;
  localparam int PHASE_CYCLES = (PHASE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] PHASE_LAST = 4'(PHASE_CYCLES - 1);
  localparam logic [7:0] LAMP_CYCLES = 8'hDF;

  // Device register offsets on the utility bus
  localparam logic [7:0] REG_REF_PORT = 8'h40;
  localparam logic [7:0] REG_REF_WIDTH = 8'h41;
  localparam logic [7:0] REG_INT_MASK = 8'h42;
  localparam logic [7:0] REG_INT_STAT = 8'h43;
  localparam logic [7:0] REG_MODE = 8'h44;
  localparam logic [1:0] REF_PORT_RST = 2'h0;
  localparam logic [7:0] REF_WIDTH_RST = 8'h01;
  localparam logic [4:0] INT_MASK_RST = 5'h00;
  localparam int INT_MARKER_BIT = 4;

  // Synchroniser idle word {ale, cs_n, rd_n, wr_n, ad[7:0]}
  localparam logic [11:0] SYNC_IDLE = 12'h700;
  localparam int SYNC_ALE = 11;
  localparam int SYNC_CS_N = 10;
  localparam int SYNC_RD_N = 9;
  localparam int SYNC_WR_N = 8;

  // Host command registers on AHB-Lite
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_WDATA = 8'h04;
  localparam logic [7:0] HOST_STATUS = 8'h08;
  localparam logic [7:0] HOST_CTRL = 8'h0C;
  localparam int CMD_WRITE_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_INT_BIT = 1;

  typedef enum logic [1:0] {
    MODE_CELLBUS16 = 2'b00,
    MODE_CELLBUS8 = 2'b01,
    MODE_NIBBLE = 2'b10,
    MODE_RESERVED = 2'b11
  } ubss_mode_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_ADDR = 3'b001,
    H_LATCH = 3'b010,
    H_STROBE = 3'b011,
    H_HOLD = 3'b100
  } ubss_host_state_t;

endpackage

// ---- verilog/ubss_if.sv ----
// Utility bus wires between the host end and the device end.
// Resolves the shared address/data bus and the open-drain interrupt.
`timescale 1ns/100ps
interface ubss_if;
  logic [7:0] ad_host;
  logic ad_host_oe;
  logic [7:0] ad_dev;
  logic ad_dev_oe;
  logic ale;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic rst_n;
  logic int_dev_out;
  logic int_dev_oe;
  logic [7:0] ad_bus;
  logic int_n;

  // Undriven bus floats high as through weak pull-ups
  assign ad_bus = ad_dev_oe ? ad_dev : (ad_host_oe ? ad_host : 8'hFF);
  assign int_n = int_dev_oe ? int_dev_out : 1'b1;

  modport device (
    input ad_bus, ale, cs_n, rd_n, wr_n, rst_n,
    output ad_dev, ad_dev_oe, int_dev_out, int_dev_oe
  );
  modport host (
    input ad_bus, int_n,
    output ad_host, ad_host_oe, ale, cs_n, rd_n, wr_n, rst_n
  );
endinterface

// ---- verilog/ubss_device.sv ----
// Device end: utility bus register slave, interrupt, mode select,
// receive activity lamps and receive timing marker.
// Assumes ref_clk is the line rate clock and bus pins are asynchronous.
// Notes on behaviour
// RULE1: Read: latch address, then rd and cs low.
// RULE2: Write: latch address, data on bus, wr and cs.
// RULE3: Write data taken when wr or cs releases.
// RULE4: Interrupt is open drain, only pulled low.
// RULE5: Interrupt holds until its status is read.
// RULE6: Per-source mask gates the interrupt.
// RULE7: Mode pins select the cell interface; 11 reserved.
// RULE8: Lamps and marker timed from line clock.
// RULE9: Reset low clears all control state asynchronously.
// RULE10: Host resets the device after power up.
// RULE11: Lamp low 223 cycles from cell start.
// RULE12: Only good non-idle cells light the lamp.
// RULE13: Timing command pulses marker low, programmable width.
// RULE14: Rx_reference_port_select selects the marker port.
// RULE15: Fast ports need width above its default.
// RULE16: Bus strobes synchronised before use.
// RULE17: Address latched on address strobe fall.
// RULE18: Address strobe low while bus carries data.
// RULE19: Chip select needed; may stay low.
// RULE20: Device drives bus only during reads.
`timescale 1ns/100ps
module ubss_device (
  input wire logic ref_clk, // Line rate clock
  input wire logic reset, // Asynchronous reset, active high
  ubss_if.device ub, // Utility bus
  input wire logic [1:0] mode, // Static cell interface select
  input wire logic [3:0] rx_cell_start, // Per-port start of received cell
  input wire logic [3:0] rx_cell_good, // Cell is neither idle nor errored
  input wire logic [3:0] rx_timing_cmd, // Per-port timing command byte seen
  output logic [3:0] rx_activity_lamp_n, // Per-port activity, low active
  output logic rx_timing_marker_n, // Timing marker pulse, low active
  output logic [1:0] cell_if_mode, // Registered mode selection
  output logic mode_reserved // Mode pins hold the reserved code
);

  // Either reset clears everything; the bus reset comes from the host
  wire clear = reset | ~ub.rst_n; // RULE9

  logic [11:0] meta_reg;
  logic [11:0] sync_reg;
  logic [11:0] prev_reg;
  logic [7:0] addr_reg;
  logic [1:0] ref_port_reg;
  logic [7:0] ref_width_reg;
  logic [4:0] int_mask_reg;
  logic [4:0] int_stat_reg;
  logic [4:0] int_stat_next;
  logic int_oe_reg;
  logic [7:0] ad_out_reg;
  logic ad_oe_reg;
  logic [7:0] marker_cnt_reg;
  logic [7:0] marker_cnt_next;
  logic marker_n_reg;
  logic [1:0] mode_reg;
  logic mode_rsvd_reg;

  wire [11:0] pins = {ub.ale, ub.cs_n, ub.rd_n, ub.wr_n, ub.ad_bus};

  // Only sync_reg reads meta_reg; prev_reg gives edges and the held data
  always_ff @(posedge ref_clk or posedge clear) begin
    if (clear) begin
      meta_reg <= ubss_pkg::SYNC_IDLE;
      sync_reg <= ubss_pkg::SYNC_IDLE;
      prev_reg <= ubss_pkg::SYNC_IDLE;
    end else begin
      meta_reg <= pins; // RULE16
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  wire cs_now = ~sync_reg[ubss_pkg::SYNC_CS_N]; // RULE19
  wire cs_was = ~prev_reg[ubss_pkg::SYNC_CS_N];
  wire rd_acc = cs_now & ~sync_reg[ubss_pkg::SYNC_RD_N];
  wire rd_acc_was = cs_was & ~prev_reg[ubss_pkg::SYNC_RD_N];
  wire wr_acc = cs_now & ~sync_reg[ubss_pkg::SYNC_WR_N];
  wire wr_acc_was = cs_was & ~prev_reg[ubss_pkg::SYNC_WR_N];
  wire ale_fall = prev_reg[ubss_pkg::SYNC_ALE] & ~sync_reg[ubss_pkg::SYNC_ALE];
  wire rd_start = rd_acc & ~rd_acc_was;
  wire rd_end = rd_acc_was & ~rd_acc;
  // Whichever of wr or cs lets go first ends the write
  wire wr_end = wr_acc_was & ~wr_acc; // RULE3
  // Data from the stage where the strobe was still active
  wire [7:0] ad_held = prev_reg[7:0];

  function automatic logic hit(input logic strobe, input logic [7:0] a,
                               input logic [7:0] target);
    hit = strobe & (a == target);
  endfunction

  always_ff @(posedge ref_clk or posedge clear) begin
    if (clear) begin
      addr_reg <= 8'h00;
    end else if (ale_fall) begin
      addr_reg <= ad_held; // RULE17
    end
  end

  always_ff @(posedge ref_clk or posedge clear) begin
    if (clear) begin
      ref_port_reg <= ubss_pkg::REF_PORT_RST;
      ref_width_reg <= ubss_pkg::REF_WIDTH_RST;
      int_mask_reg <= ubss_pkg::INT_MASK_RST;
    end else begin
      if (hit(wr_end, addr_reg, ubss_pkg::REG_REF_PORT)) begin
        ref_port_reg <= ad_held[1:0]; // RULE14
      end
      if (hit(wr_end, addr_reg, ubss_pkg::REG_REF_WIDTH)) begin
        ref_width_reg <= ad_held; // RULE13
      end
      if (hit(wr_end, addr_reg, ubss_pkg::REG_INT_MASK)) begin
        int_mask_reg <= ad_held[4:0]; // RULE6
      end
    end
  end

  wire [7:0] rd_data =
    (addr_reg == ubss_pkg::REG_REF_PORT) ? {6'h00, ref_port_reg} :
    (addr_reg == ubss_pkg::REG_REF_WIDTH) ? ref_width_reg :
    (addr_reg == ubss_pkg::REG_INT_MASK) ? {3'h0, int_mask_reg} :
    (addr_reg == ubss_pkg::REG_INT_STAT) ? {3'h0, int_stat_reg} :
    (addr_reg == ubss_pkg::REG_MODE) ? {5'h00, mode_rsvd_reg, mode_reg} :
    8'h00;

  // Snapshot at read start so the clear matches exactly what was read
  always_ff @(posedge ref_clk or posedge clear) begin
    if (clear) begin
      ad_out_reg <= 8'h00;
      ad_oe_reg <= 1'b0;
    end else begin
      ad_oe_reg <= rd_acc; // RULE20
      if (rd_start) begin
        ad_out_reg <= rd_data;
      end
    end
  end

  // Good cells and the marker trigger are the interrupt sources
  wire [3:0] cell_ok = rx_cell_start & rx_cell_good; // RULE12
  wire marker_trig = rx_timing_cmd[ref_port_reg]; // RULE14
  wire [4:0] events = {marker_trig, cell_ok};
  wire [4:0] stat_clear =
    hit(rd_end, addr_reg, ubss_pkg::REG_INT_STAT) ? ad_out_reg[4:0] : 5'h00;

  // A new event wins over a clear in the same cycle
  assign int_stat_next = (int_stat_reg & ~stat_clear) | events; // RULE5

  always_ff @(posedge ref_clk or posedge clear) begin
    if (clear) begin
      int_stat_reg <= 5'h00;
      int_oe_reg <= 1'b0;
    end else begin
      int_stat_reg <= int_stat_next;
      int_oe_reg <= |(int_stat_next & int_mask_reg); // RULE6
    end
  end

  assign ub.int_dev_out = 1'b0; // RULE4
  assign ub.int_dev_oe = int_oe_reg;
  assign ub.ad_dev = ad_out_reg;
  assign ub.ad_dev_oe = ad_oe_reg;

  // A zero width would give no pulse, so it counts as one cycle
  wire [7:0] width_eff = (ref_width_reg == 8'h00) ? 8'h01 : ref_width_reg; // RULE15
  assign marker_cnt_next = marker_trig ? width_eff :
    (marker_cnt_reg != 8'h00) ? marker_cnt_reg - 8'h01 : 8'h00;

  always_ff @(posedge ref_clk or posedge clear) begin
    if (clear) begin
      marker_cnt_reg <= 8'h00;
      marker_n_reg <= 1'b1;
    end else begin
      marker_cnt_reg <= marker_cnt_next; // RULE8
      marker_n_reg <= (marker_cnt_next == 8'h00); // RULE13
    end
  end
  assign rx_timing_marker_n = marker_n_reg;

  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_lamp
      logic [7:0] cnt_reg;
      logic lamp_n_reg;
      wire [7:0] cnt_next = cell_ok[p] ? ubss_pkg::LAMP_CYCLES :
        (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
      always_ff @(posedge ref_clk or posedge clear) begin
        if (clear) begin
          cnt_reg <= 8'h00;
          lamp_n_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_next; // RULE8
          lamp_n_reg <= (cnt_next == 8'h00); // RULE11
        end
      end
      assign rx_activity_lamp_n[p] = lamp_n_reg;
    end
  endgenerate

  // Mode is static; it is sampled every cycle and decoded for the cell side
  always_ff @(posedge ref_clk or posedge clear) begin
    if (clear) begin
      mode_reg <= ubss_pkg::MODE_CELLBUS16;
      mode_rsvd_reg <= 1'b0;
    end else begin
      mode_reg <= mode; // RULE7
      mode_rsvd_reg <= (mode == ubss_pkg::MODE_RESERVED);
    end
  end
  assign cell_if_mode = mode_reg;
  assign mode_reserved = mode_rsvd_reg;

endmodule

// ---- verilog/ubss_host.sv ----
// Host end: AHB-Lite command registers driving utility bus cycles.
// Assumes a zero-wait AHB-Lite master and the device on the same clock.
`timescale 1ns/100ps
module ubss_host (
  input wire logic ref_clk, // System clock
  input wire logic reset, // Asynchronous reset, active high
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Low in reset, then always ready
  output logic hresp, // Always OKAY
  ubss_if.host ub // Utility bus
);

  logic wpend_reg;
  logic [7:0] waddr_reg;
  logic [31:0] hrdata_reg;
  logic hready_reg;
  logic [7:0] cmd_addr_reg;
  logic cmd_write_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic rst_n_reg;
  logic [3:0] cnt_reg;
  ubss_pkg::ubss_host_state_t state_reg;
  ubss_pkg::ubss_host_state_t state_next;
  logic [7:0] ad_next;
  logic oe_next;
  logic ale_next;
  logic cs_n_next;
  logic rd_n_next;
  logic wr_n_next;
  logic [7:0] ad_reg;
  logic oe_reg;
  logic ale_reg;
  logic cs_n_reg;
  logic rd_n_reg;
  logic wr_n_reg;

  wire take = hsel & hready & htrans[1];
  wire busy = (state_reg != ubss_pkg::H_IDLE);
  wire phase_done = (cnt_reg == ubss_pkg::PHASE_LAST);
  wire cmd_go = wpend_reg & (waddr_reg == ubss_pkg::HOST_CMD) & ~busy;

  wire [31:0] rd_mux =
    (haddr[7:0] == ubss_pkg::HOST_CMD) ? {23'h0, cmd_write_reg, cmd_addr_reg} :
    (haddr[7:0] == ubss_pkg::HOST_WDATA) ? {24'h0, wdata_reg} :
    (haddr[7:0] == ubss_pkg::HOST_STATUS) ?
      {16'h0, rdata_reg, 6'h00, ~ub.int_n, busy} :
    (haddr[7:0] == ubss_pkg::HOST_CTRL) ? {31'h0, ~rst_n_reg} :
    32'h0000_0000;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wpend_reg <= 1'b0;
      waddr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      hready_reg <= 1'b0;
    end else begin
      hready_reg <= 1'b1;
      wpend_reg <= take & hwrite;
      if (take) begin
        waddr_reg <= haddr[7:0];
      end
      if (take & ~hwrite) begin
        hrdata_reg <= rd_mux;
      end
    end
  end
  assign hrdata = hrdata_reg;
  assign hreadyout = hready_reg;
  assign hresp = 1'b0;

  // Device held in reset from power up until software releases it
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rst_n_reg <= 1'b0; // RULE10
      cmd_addr_reg <= 8'h00;
      cmd_write_reg <= 1'b0;
      wdata_reg <= 8'h00;
    end else if (wpend_reg) begin
      if (waddr_reg == ubss_pkg::HOST_CTRL) begin
        rst_n_reg <= ~hwdata[0]; // RULE10
      end
      if ((waddr_reg == ubss_pkg::HOST_WDATA) & ~busy) begin
        wdata_reg <= hwdata[7:0];
      end
      if (cmd_go) begin
        cmd_addr_reg <= hwdata[7:0];
        cmd_write_reg <= hwdata[ubss_pkg::CMD_WRITE_BIT];
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ubss_pkg::H_IDLE: if (cmd_go) state_next = ubss_pkg::H_ADDR;
      ubss_pkg::H_ADDR: if (phase_done) state_next = ubss_pkg::H_LATCH;
      ubss_pkg::H_LATCH: if (phase_done) state_next = ubss_pkg::H_STROBE;
      ubss_pkg::H_STROBE: if (phase_done) state_next = ubss_pkg::H_HOLD;
      ubss_pkg::H_HOLD: if (phase_done) state_next = ubss_pkg::H_IDLE;
      default: state_next = ubss_pkg::H_IDLE;
    endcase
  end

  // Pin values follow the next state so they leave flip-flops
  wire [7:0] cmd_addr_now = cmd_go ? hwdata[7:0] : cmd_addr_reg;
  always_comb begin
    ad_next = 8'h00;
    oe_next = 1'b0;
    ale_next = 1'b0;
    cs_n_next = 1'b1;
    rd_n_next = 1'b1;
    wr_n_next = 1'b1;
    unique case (state_next)
      ubss_pkg::H_IDLE: ;
      ubss_pkg::H_ADDR: begin
        ad_next = cmd_addr_now;
        oe_next = 1'b1;
        ale_next = 1'b1;
      end
      // Address strobe falls with the address still on the bus
      ubss_pkg::H_LATCH: begin
        ad_next = cmd_addr_reg; // RULE18
        oe_next = 1'b1;
      end
      ubss_pkg::H_STROBE: begin
        cs_n_next = 1'b0;
        ad_next = wdata_reg;
        oe_next = cmd_write_reg; // RULE2
        rd_n_next = cmd_write_reg; // RULE1
        wr_n_next = ~cmd_write_reg;
      end
      // Write data stays on past the strobe release for the capture
      ubss_pkg::H_HOLD: begin
        ad_next = wdata_reg;
        oe_next = cmd_write_reg; // RULE2
      end
      default: ;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ubss_pkg::H_IDLE;
      cnt_reg <= 4'h0;
      rdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= (state_next != state_reg) ? 4'h0 : cnt_reg + 4'h1;
      if ((state_reg == ubss_pkg::H_STROBE) & phase_done & ~cmd_write_reg) begin
        rdata_reg <= ub.ad_bus; // RULE1
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ad_reg <= 8'h00;
      oe_reg <= 1'b0;
      ale_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
    end else begin
      ad_reg <= ad_next;
      oe_reg <= oe_next;
      ale_reg <= ale_next;
      cs_n_reg <= cs_n_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
    end
  end
  assign ub.ad_host = ad_reg;
  assign ub.ad_host_oe = oe_reg;
  assign ub.ale = ale_reg;
  assign ub.cs_n = cs_n_reg;
  assign ub.rd_n = rd_n_reg;
  assign ub.wr_n = wr_n_reg;
  assign ub.rst_n = rst_n_reg;

endmodule

// ---- tb/ubss_chk.sv ----
// Checker for the utility bus between the host end and the device end.
// Assumes one clock; sees only the interface wires, no device internals.
`timescale 1ns/100ps
module ubss_chk (
  input logic ref_clk, // Line rate clock
  input logic reset, // Reset, active high
  input logic [7:0] ad_host, // Host bus value
  input logic ad_host_oe, // Host drives bus
  input logic ad_dev_oe, // Device drives bus
  input logic [7:0] ad_bus, // Resolved bus
  input logic ale, // Address latch
  input logic cs_n, // Chip select
  input logic rd_n, // Read strobe
  input logic wr_n, // Write strobe
  input logic rst_n, // Device reset
  input logic int_dev_out, // Interrupt drive value
  input logic int_dev_oe // Interrupt pull enable
);
  logic [7:0] addr_reg;
  logic [3:0] rd_age_reg;
  logic [3:0] acc_age_reg;
  wire strobe_on = !cs_n && (!rd_n || !wr_n);
  wire int_reg_hit = addr_reg == ubss_pkg::REG_INT_MASK || addr_reg == ubss_pkg::REG_INT_STAT;

  // Ages saturate so a long quiet spell never wraps into a false recent access
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      addr_reg <= 8'h00;
      rd_age_reg <= 4'hF;
      acc_age_reg <= 4'hF;
    end else begin
      addr_reg <= ale ? ad_bus : addr_reg;
      rd_age_reg <= (!cs_n && !rd_n) ? 4'h0 : rd_age_reg + {3'h0, rd_age_reg != 4'hF};
      acc_age_reg <= (strobe_on && int_reg_hit) ? 4'h0 : acc_age_reg + {3'h0, acc_age_reg != 4'hF};
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_strobe_follows;
    ##[4:8] $fell(cs_n);
  endsequence
  sequence s_data_held;
    (ad_host_oe && $stable(ad_host)) [*4];
  endsequence

  chk_int_drive_low:
    assert property (int_dev_out == 1'b0) else $error("interrupt drive value not low");
  chk_int_release:
    assert property (disable iff (reset || !rst_n) $fell(int_dev_oe) |-> acc_age_reg < 4'hC)
    else $error("interrupt released without status or mask access");
  chk_read_window:
    assert property (disable iff (reset || !rst_n) ad_dev_oe |-> rd_age_reg <= 4'h6)
    else $error("device drives bus outside a read");
  chk_read_drive:
    assert property (disable iff (reset || !rst_n) (!rd_n && !cs_n) [*6] |-> ad_dev_oe)
    else $error("device silent during read strobe");
  chk_read_release:
    assert property ($rose(rd_n) |-> ##5 !ad_dev_oe) else $error("bus still driven after read");
  chk_write_quiet:
    assert property (!wr_n |-> !ad_dev_oe && ad_host_oe) else $error("bus contention on write");
  chk_ale_data:
    assert property (strobe_on |-> !ale) else $error("address latch high during data");
  chk_strobe_excl:
    assert property (!rd_n |-> wr_n) else $error("read and write strobes together");
  chk_write_hold:
    assert property ($rose(wr_n) |-> s_data_held) else $error("write data gone at strobe release");
  chk_addr_first:
    assert property ($fell(ale) |-> s_strobe_follows) else $error("no strobe after address");
  chk_reset_quiet:
    assert property ($rose(rst_n) |-> !ad_dev_oe && !int_dev_oe) else $error("outputs live in reset");
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench: AHB-Lite master into the host end, device end across the utility bus.
// Assumes one 50 MHz clock and the package constants.
`timescale 1ns/100ps
module testbench;
  typedef struct {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] exp;} ubss_row_t;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] mode = 2'h0;
  logic [3:0] rx_cell_start = 4'h0;
  logic [3:0] rx_cell_good = 4'h0;
  logic [3:0] rx_timing_cmd = 4'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [3:0] rx_activity_lamp_n;
  logic rx_timing_marker_n;
  logic [1:0] cell_if_mode;
  logic mode_reserved;
  logic [31:0] rdat;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  wire [4:0] lows = {rx_timing_marker_n, rx_activity_lamp_n};
  ubss_row_t rows [7] = '{'{1'b0, 8'h40, 8'h00, 8'h00}, '{1'b0, 8'h41, 8'h00, 8'h01},
    '{1'b0, 8'h42, 8'h00, 8'h00}, '{1'b1, 8'h40, 8'h03, 8'h03}, '{1'b1, 8'h41, 8'h05, 8'h05},
    '{1'b1, 8'h42, 8'h1F, 8'h1F}, '{1'b1, 8'h45, 8'hAA, 8'h00}};

  ubss_if ub_if();
  ubss_host u_ubss_host (.ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ub(ub_if));
  ubss_device u_ubss_device (.ref_clk, .reset, .ub(ub_if), .mode, .rx_cell_start, .rx_cell_good,
    .rx_timing_cmd, .rx_activity_lamp_n, .rx_timing_marker_n, .cell_if_mode, .mode_reserved);
  ubss_chk u_ubss_chk (.ref_clk, .reset, .ad_host(ub_if.ad_host), .ad_host_oe(ub_if.ad_host_oe),
    .ad_dev_oe(ub_if.ad_dev_oe), .ad_bus(ub_if.ad_bus), .ale(ub_if.ale), .cs_n(ub_if.cs_n),
    .rd_n(ub_if.rd_n), .wr_n(ub_if.wr_n), .rst_n(ub_if.rst_n), .int_dev_out(ub_if.int_dev_out),
    .int_dev_oe(ub_if.int_dev_oe));

  always #10 ref_clk = ~ref_clk;

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A hang costs one mismatch and still reaches the verdict
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // No cycle limit here: only the run's timeout may end a wait
  task automatic wait_ready;
    do begin
      @(posedge ref_clk);
    end while (hreadyout !== 1'b1);
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rdat = hrdata;
  endtask

  // One utility bus cycle; read data lands in rdat[15:8]
  task automatic dev_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
    ahb(1'b1, ubss_pkg::HOST_WDATA, {24'h0, d});
    ahb(1'b1, ubss_pkg::HOST_CMD, {23'h0, wr, a});
    do begin
      ahb(1'b0, ubss_pkg::HOST_STATUS, 32'h0);
    end while (rdat[ubss_pkg::STAT_BUSY_BIT] !== 1'b0);
  endtask

  task automatic pulse(input logic cmd, input int p, input logic good);
    rx_timing_cmd <= cmd ? 4'h1 << p : 4'h0;
    rx_cell_start <= cmd ? 4'h0 : 4'h1 << p;
    rx_cell_good <= good ? 4'h1 << p : 4'h0;
    @(posedge ref_clk);
    rx_timing_cmd <= 4'h0;
    rx_cell_start <= 4'h0;
    rx_cell_good <= 4'h0;
  endtask

  task automatic count_low(input int b, output int c);
    c = 0;
    @(negedge ref_clk);
    while (lows[b] === 1'b0 && c < 400) begin
      c++;
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    ahb(1'b1, ubss_pkg::HOST_CTRL, 32'h0);
    foreach (rows[i]) begin
      if (rows[i].wr)
        dev_op(1'b1, rows[i].a, rows[i].d);
      dev_op(1'b0, rows[i].a, 8'h00);
      check({24'h0, rdat[15:8]}, {24'h0, rows[i].exp});
      check({31'h0, hresp}, 32'h0);
    end
    for (int m = 0; m < 4; m++) begin
      mode <= 2'(m);
      repeat (4) @(posedge ref_clk);
      check({29'h0, mode_reserved, cell_if_mode}, {29'h0, m == 3, 2'(m)});
      dev_op(1'b0, ubss_pkg::REG_MODE, 8'h00);
      check({24'h0, rdat[15:8]}, {29'h0, m == 3, 2'(m)});
    end
    pulse(1'b0, 1, 1'b0);
    count_low(1, n);
    check(n, 0);
    pulse(1'b0, 2, 1'b1);
    count_low(2, n);
    check(n, ubss_pkg::LAMP_CYCLES);
    check(ub_if.int_n, 1'b0);
    dev_op(1'b0, ubss_pkg::REG_INT_STAT, 8'h00);
    check(rdat[15:8], 8'h04);
    check(ub_if.int_n, 1'b1);
    dev_op(1'b1, ubss_pkg::REG_INT_MASK, 8'h0F);
    dev_op(1'b1, ubss_pkg::REG_REF_WIDTH, 8'h03);
    for (int p = 0; p < 4; p++) begin
      dev_op(1'b1, ubss_pkg::REG_REF_PORT, 8'(p));
      pulse(1'b1, (p + 1) % 4, 1'b0);
      count_low(4, n);
      check(n, 0);
      pulse(1'b1, p, 1'b0);
      count_low(4, n);
      check(n, 3);
    end
    check(ub_if.int_n, 1'b1);
    dev_op(1'b1, ubss_pkg::REG_INT_MASK, 8'h1F);
    check(ub_if.int_n, 1'b0);
    dev_op(1'b0, ubss_pkg::REG_INT_STAT, 8'h00);
    check(rdat[15:8], 8'h10);
    pulse(1'b0, 0, 1'b1);
    ahb(1'b1, ubss_pkg::HOST_CTRL, 32'h1);
    repeat (2) @(posedge ref_clk);
    check({27'h0, ub_if.int_n, rx_activity_lamp_n}, 32'h1F);
    ahb(1'b1, ubss_pkg::HOST_CTRL, 32'h0);
    dev_op(1'b0, ubss_pkg::REG_INT_MASK, 8'h00);
    check(rdat[15:8], 8'h00);
    dev_op(1'b0, ubss_pkg::REG_REF_WIDTH, 8'h00);
    check(rdat[15:8], 8'h01);
    end_of_test();
  end
endmodule
